// ==== src/cmbm_top.sv ====
// Code memory boot and map control with wait states and memory lock.
//
// Overview of operation
// - After every reset, fetch starts from the boot ROM.
// - Boot ROM spans 0x0000-0x07FF; code flash spans 0x0000-0xFFFF.
// - Boot-select high runs in-system programming code.
// - Boot-select low jumps straight to the start stub.
// - Start stub switches the map, then jumps to flash address 0x0000.
// - Initial map: ROM and stub in code space, flash in data space.
// - ROM overlaps 0x0000-0x07FF, stub overlaps 0xFFF7-0xFFFF.
// - Initial map: flash writable via data space only, not fetchable.
// - Map switch removes boot ROM and maps code flash in its place.
// - Config register layout fixed; reset value 0x00.
// - In the user map, clearing the stub-map flag disables the stub region at once.
// - Code fetches insert wait states equal to the wait-state register.
// - Memory lock refuses outside and debugger access.
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ns
module cmbm_top (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic srst_in,
  // Pins and lock strap.
  input wire logic boot_select_pin_in,
  input wire logic lock_set_in,
  // Avalon-MM register slave.
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Core fetch path.
  input wire logic [15:0] fetch_addr_in,
  input wire logic fetch_req_in,
  output logic fetch_ready_out,
  output cmbm_pkg::cmbm_src_t fetch_src_out,
  output logic stub_done_out,
  // Map state and outside access.
  output logic flash_in_code_out,
  output logic flash_data_write_ok_out,
  output logic prog_mode_out,
  output logic [2:0] external_memory_mode_out,
  input wire logic ext_access_req_in,
  output logic ext_access_grant_out
);
  import cmbm_pkg::*;
  logic boot_sync1, boot_sync2, lock_sync1, lock_sync2;
  cmbm_state_t state, next_state;
  logic [7:0] memory_config, next_memory_config;
  logic [7:0] code_wait_states, next_code_wait_states;
  logic locked, next_locked;
  logic [31:0] rdata, next_rdata;
  logic ack, next_ack;
  logic [7:0] wcount, next_wcount;
  logic ready, next_ready;
  cmbm_src_t src, next_src;
  logic grant, next_grant;
  logic busy;
  logic waitreq, next_waitreq;

  // Source of a fetch under the current map and stub flag.
  // Before the switch the flash is never a fetch source; the middle region falls back
  // to the boot ROM so that a stray jump stays in known code.
  // Setting the stub-map flag again in the user map brings the stub back over the flash top.
  function automatic cmbm_src_t map_src(input cmbm_state_t st, input logic [15:0] a,
                                        input logic stub_on);
    if (st != CMBM_USER) begin
      map_src = (a <= CMBM_ROM_LAST) ? CMBM_SRC_ROM :
                (a >= CMBM_STUB_FIRST) ? CMBM_SRC_STUB : CMBM_SRC_ROM;
    end else if (stub_on && a >= CMBM_STUB_FIRST && a <= CMBM_FLASH_LAST) begin
      map_src = CMBM_SRC_STUB;
    end else begin
      map_src = CMBM_SRC_FLASH;
    end
  endfunction

  // Pins pass two flip-flops before any logic sees them.
  always_ff @(posedge clk_in) begin
    boot_sync1 <= boot_select_pin_in;
    boot_sync2 <= boot_sync1;
    lock_sync1 <= lock_set_in;
    lock_sync2 <= lock_sync1;
  end

  // Boot sequence. The stub fetch at the top region marks the map switch point.
  always_comb begin
    next_state = state;
    unique case (state)
      CMBM_BOOT: next_state = boot_sync2 ? CMBM_PROG : CMBM_STUB;
      CMBM_PROG: next_state = CMBM_PROG;
      // Limitation: any completed fetch from the stub region counts as stub entry, so
      // boot code must not read the top region for another purpose before it jumps there.
      CMBM_STUB: begin
        if (fetch_req_in && ready && fetch_addr_in >= CMBM_STUB_FIRST) begin
          next_state = CMBM_USER;
        end
      end
      CMBM_USER: next_state = CMBM_USER;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state <= CMBM_BOOT;
    end else begin
      state <= next_state;
    end
  end

  // Register slave. One wait cycle, then the answer with waitrequest low.
  assign busy = (avs_read_in || avs_write_in) && !ack;

  always_comb begin
    next_memory_config = memory_config;
    next_code_wait_states = code_wait_states;
    // The lock is sticky: strap or software sets it and only reset clears it, so
    // toggling the strap cannot reopen the memories to a debugger.
    next_locked = locked | lock_sync2;
    next_rdata = rdata;
    next_ack = busy;
    next_waitreq = !busy;
    // A write lands on the edge at which the master sees waitrequest low, so a request
    // that is still waiting never changes a register.
    if (ack && avs_write_in) begin
      unique case (avs_address_in)
        CMBM_CONF_ADDR: next_memory_config = avs_writedata_in[7:0] & CMBM_CONF_WMASK;
        CMBM_WAIT_ADDR: next_code_wait_states = avs_writedata_in[7:0];
        CMBM_LOCK_ADDR: next_locked = locked | avs_writedata_in[CMBM_LOCK_BIT] | lock_sync2;
        default: next_code_wait_states = code_wait_states;
      endcase
    end
    // Read data is captured on the wait edge and stands while waitrequest is low.
    if (busy && avs_read_in) begin
      unique case (avs_address_in)
        CMBM_CONF_ADDR: next_rdata = {24'h000000, memory_config};
        CMBM_WAIT_ADDR: next_rdata = {24'h000000, code_wait_states};
        CMBM_LOCK_ADDR: next_rdata = {31'h00000000, locked};
        CMBM_STAT_ADDR: next_rdata = {28'h0000000, boot_sync2, 1'b0, state};
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      memory_config <= CMBM_CONF_RESET;
      code_wait_states <= CMBM_WAIT_RESET;
      locked <= 1'b0;
      rdata <= 32'h00000000;
      ack <= 1'b0;
      waitreq <= 1'b1;
    end else begin
      memory_config <= next_memory_config;
      code_wait_states <= next_code_wait_states;
      locked <= next_locked;
      rdata <= next_rdata;
      ack <= next_ack;
      waitreq <= next_waitreq;
    end
  end

  // Fetch wait states: ready rises after code_wait_states idle cycles.
  // A new wait-state value acts on a running count, so software should change it
  // only while the core is not fetching from the memories it governs.
  always_comb begin
    next_wcount = wcount;
    next_ready = 1'b0;
    next_src = src;
    next_grant = ext_access_req_in && !locked;
    if (!fetch_req_in || ready) begin
      next_wcount = 8'h00;
    end else if (wcount >= code_wait_states) begin
      next_ready = 1'b1;
      next_src = map_src(state, fetch_addr_in, memory_config[CMBM_STUB_BIT]);
    end else begin
      next_wcount = wcount + 8'h01;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wcount <= 8'h00;
      ready <= 1'b0;
      src <= CMBM_SRC_ROM;
      grant <= 1'b0;
    end else begin
      wcount <= next_wcount;
      ready <= next_ready;
      src <= next_src;
      grant <= next_grant;
    end
  end

  // Map state outputs are registered; flash code use follows the switch.
  logic flash_code, next_flash_code;
  logic data_ok, next_data_ok;
  logic done, next_done;

  // Flash leaves data space and enters code space on the very edge of the switch.
  always_comb begin
    next_flash_code = (next_state == CMBM_USER);
    next_data_ok = (next_state != CMBM_USER);
    next_done = (state == CMBM_STUB) && (next_state == CMBM_USER);
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      flash_code <= 1'b0;
      data_ok <= 1'b1;
      done <= 1'b0;
    end else begin
      flash_code <= next_flash_code;
      data_ok <= next_data_ok;
      done <= next_done;
    end
  end

  // Outputs come straight from flops so no decode glitch reaches the core or the bus.
  assign avs_readdata_out = rdata;
  assign avs_waitrequest_out = waitreq;
  assign fetch_ready_out = ready;
  assign fetch_src_out = src;
  assign stub_done_out = done;
  assign flash_in_code_out = flash_code;
  assign flash_data_write_ok_out = data_ok;
  assign prog_mode_out = memory_config[CMBM_PROG_BIT];
  assign external_memory_mode_out = memory_config[CMBM_MODE_HI:CMBM_MODE_LO];
  assign ext_access_grant_out = grant;

  stub_off_a: assert property (@(posedge clk_in) disable iff (srst_in)
    ($past(state) == CMBM_USER && !$past(memory_config[CMBM_STUB_BIT]) && ready)
    |-> src != CMBM_SRC_STUB)
    else $error("stub region served after flag cleared");
  boot_rom_a: assert property (@(posedge clk_in)
    srst_in |=> state == CMBM_BOOT && !flash_in_code_out)
    else $error("reset did not return to boot rom");
  lock_deny_a: assert property (@(posedge clk_in) disable iff (srst_in)
    locked |=> !ext_access_grant_out)
    else $error("access granted while locked");
  reserved_zero_a: assert property (@(posedge clk_in) disable iff (srst_in)
    !memory_config[CMBM_RSVD_BIT]) else $error("reserved bit set");
  wait_cnt_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (fetch_req_in && ready) |-> $past(wcount) == code_wait_states)
    else $error("wait state count wrong");
  prog_stay_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (state == CMBM_BOOT && boot_sync2) |=> state == CMBM_PROG)
    else $error("programming path not taken");
  stub_go_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (state == CMBM_BOOT && !boot_sync2) |=> state == CMBM_STUB)
    else $error("stub path not taken");
  init_map_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (state != CMBM_USER && ready) |-> src != CMBM_SRC_FLASH)
    else $error("flash fetched before map switch");
  conf_reset_a: assert property (@(posedge clk_in)
    srst_in |=> memory_config == CMBM_CONF_RESET)
    else $error("config reset value wrong");

  // Answer timing of both interfaces and the source chosen for each region.
  bus_answer_a: assert property (@(posedge clk_in) disable iff (srst_in)
    ((avs_read_in || avs_write_in) && avs_waitrequest_out) |=> !avs_waitrequest_out)
    else $error("register bus answer late");
  ready_pulse_a: assert property (@(posedge clk_in) disable iff (srst_in)
    fetch_ready_out |=> !fetch_ready_out)
    else $error("fetch ready longer than one cycle");
  wait_hold_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (fetch_req_in && !ready && wcount < code_wait_states) |=> !fetch_ready_out)
    else $error("fetch answered before its wait states");
  src_stand_a: assert property (@(posedge clk_in) disable iff (srst_in)
    !fetch_ready_out |-> $stable(fetch_src_out))
    else $error("fetch source moved without an answer");
  rom_low_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (ready && $past(state) != CMBM_USER && $past(fetch_addr_in) <= CMBM_ROM_LAST)
    |-> src == CMBM_SRC_ROM)
    else $error("low code address not served by boot rom");
  stub_top_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (ready && $past(state) != CMBM_USER && $past(fetch_addr_in) >= CMBM_STUB_FIRST)
    |-> src == CMBM_SRC_STUB)
    else $error("top code address not served by stub");
  user_flash_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (ready && $past(state) == CMBM_USER && $past(fetch_addr_in) < CMBM_STUB_FIRST)
    |-> src == CMBM_SRC_FLASH)
    else $error("user map fetch not served by flash");
  switch_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (state == CMBM_STUB && fetch_req_in && ready && fetch_addr_in >= CMBM_STUB_FIRST)
    |=> stub_done_out && flash_in_code_out && !flash_data_write_ok_out)
    else $error("map switch not made at stub entry");
  lock_hold_a: assert property (@(posedge clk_in) disable iff (srst_in)
    locked |=> locked)
    else $error("memory lock released without reset");
  path_hold_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (state == CMBM_PROG || state == CMBM_USER) |=> state == $past(state))
    else $error("boot path left without reset");

  // Covers for the main boot paths and for a fetch with wait states.
  switch_c: cover property (@(posedge clk_in) disable iff (srst_in) stub_done_out);
  slow_c: cover property (@(posedge clk_in) disable iff (srst_in)
    fetch_ready_out && code_wait_states != CMBM_WAIT_RESET);
  prog_c: cover property (@(posedge clk_in) disable iff (srst_in) state == CMBM_PROG);
  unstub_c: cover property (@(posedge clk_in) disable iff (srst_in)
    state == CMBM_USER && !memory_config[CMBM_STUB_BIT]);
  lock_c: cover property (@(posedge clk_in) disable iff (srst_in) locked && ext_access_req_in);
endmodule

// ==== src/cmbm_pkg.sv ====
// Package with register map, field layout and map constants for the boot map block.
package cmbm_pkg;
  localparam logic [7:0] CMBM_WAIT_ADDR = 8'h92;
  localparam logic [7:0] CMBM_CONF_ADDR = 8'hFF;
  localparam logic [7:0] CMBM_LOCK_ADDR = 8'h90;
  localparam logic [7:0] CMBM_STAT_ADDR = 8'h91;
  localparam logic [7:0] CMBM_CONF_RESET = 8'h00;
  localparam logic [7:0] CMBM_WAIT_RESET = 8'h00;
  localparam logic [7:0] CMBM_CONF_WMASK = 8'hFB;
  localparam int CMBM_STUB_BIT = 7;
  localparam int CMBM_PROG_BIT = 6;
  localparam int CMBM_MODE_HI = 5;
  localparam int CMBM_MODE_LO = 3;
  localparam int CMBM_RSVD_BIT = 2;
  localparam int CMBM_LOCK_BIT = 0;
  localparam logic [15:0] CMBM_ROM_LAST = 16'h07FF;
  localparam logic [15:0] CMBM_STUB_FIRST = 16'hFFF7;
  localparam logic [15:0] CMBM_FLASH_LAST = 16'hFFFF;
  localparam logic [15:0] CMBM_APP_START = 16'h0000;
  typedef enum logic [1:0] {
    CMBM_BOOT = 2'b00,
    CMBM_PROG = 2'b01,
    CMBM_STUB = 2'b10,
    CMBM_USER = 2'b11
  } cmbm_state_t;
  typedef enum logic [1:0] {
    CMBM_SRC_ROM = 2'b00,
    CMBM_SRC_STUB = 2'b01,
    CMBM_SRC_FLASH = 2'b10
  } cmbm_src_t;
endpackage

// ==== tb/cmbm_core_model.sv ====
// Core-side fetch requester that holds each request until the block answers.
`timescale 1ns/1ns
module cmbm_core_model (
  // Clock.
  input wire logic clk_in,
  // Answer from the block.
  input wire logic ready_in,
  input cmbm_pkg::cmbm_src_t src_in,
  // Request to the block.
  output logic [15:0] addr_out,
  output logic req_out
);
  import cmbm_pkg::*;
  initial begin
    addr_out = 16'h0000;
    req_out = 1'b0;
  end
  // The idle address is inverted so a stale value never looks like the last request.
  task automatic fetch(input logic [15:0] a, input int stall, output cmbm_src_t s,
                       output int lat);
    lat = 0;
    repeat (stall) @(posedge clk_in);
    addr_out <= a;
    req_out <= 1'b1;
    do begin
      @(posedge clk_in);
      lat++;
    end while (ready_in !== 1'b1);
    s = src_in;
    req_out <= 1'b0;
    addr_out <= ~a;
    @(posedge clk_in);
  endtask
endmodule

// ==== tb/tb.sv ====
// Testbench for the boot map block with a reference model of its config and wait-state registers.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin errors++; \
  $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module tb;
  import cmbm_pkg::*;
  logic clk_in = 0, srst_in = 1, pin = 0, lock = 0, ext = 0, rd = 0, wr = 0;
  logic [7:0] adr = 8'h00, cfg, ws;
  logic [31:0] wd = 32'h00000000, rdata, q;
  logic wait_n, fr, ready, done, fic, fwo, pm, grant;
  logic [15:0] fa;
  logic [2:0] em;
  cmbm_src_t src, s;
  int errors = 0, checks = 0, seed = 32'h3BD3CECE, lat, dones = 0;
  logic [7:0] m_conf = CMBM_CONF_RESET, m_ws = CMBM_WAIT_RESET;
  logic [31:0] exp_q[$];
  cmbm_top i_dut (.clk_in(clk_in), .srst_in(srst_in), .boot_select_pin_in(pin),
    .lock_set_in(lock), .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_n),
    .fetch_addr_in(fa), .fetch_req_in(fr), .fetch_ready_out(ready), .fetch_src_out(src),
    .stub_done_out(done), .flash_in_code_out(fic), .flash_data_write_ok_out(fwo),
    .prog_mode_out(pm), .external_memory_mode_out(em), .ext_access_req_in(ext),
    .ext_access_grant_out(grant));
  cmbm_core_model i_core (.clk_in(clk_in), .ready_in(ready), .src_in(src), .addr_out(fa),
    .req_out(fr));
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    if (done === 1'b1) dones++;
  end
  task automatic print_verdict;
    if (errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  function automatic logic [31:0] model_rd(input logic [7:0] a);
    model_rd = 32'h00000000;
    if (a == CMBM_CONF_ADDR) model_rd = {24'h000000, m_conf};
    if (a == CMBM_WAIT_ADDR) model_rd = {24'h000000, m_ws};
  endfunction
  // The request is held until waitrequest is seen low, so no answer latency is assumed.
  task automatic rw(input logic we, input logic [7:0] a, input logic [7:0] d,
                    output logic [31:0] r);
    logic [31:0] e;
    if (!we && a != CMBM_STAT_ADDR && a != CMBM_LOCK_ADDR) exp_q.push_back(model_rd(a));
    adr <= a;
    wr <= we;
    rd <= !we;
    wd <= {24'h000000, d};
    do begin
      @(posedge clk_in);
    end while (wait_n !== 1'b0);
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (we && a == CMBM_CONF_ADDR) m_conf = d & 8'hFB;
    if (we && a == CMBM_WAIT_ADDR) m_ws = d;
    if (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      `CHK("model read", e, r)
    end
    @(posedge clk_in);
  endtask
  // The pin is set with reset so it is stable long before release.
  task automatic boot(input logic p);
    srst_in <= 1'b1;
    pin <= p;
    repeat (8) @(posedge clk_in);
    srst_in <= 1'b0;
    dones = 0;
    m_conf = CMBM_CONF_RESET;
    m_ws = CMBM_WAIT_RESET;
    @(posedge clk_in);
  endtask
  task automatic fetch(input logic [15:0] a, input cmbm_src_t e);
    i_core.fetch(a, $random(seed) & 3, s, lat);
    `CHK("fetch source", e, s)
  endtask
  initial begin
    repeat (20000) @(posedge clk_in);
    errors++;
    print_verdict();
  end
  initial begin
    boot(1'b1);
    rw(1'b0, CMBM_STAT_ADDR, 8'h00, q);
    `CHK("boot state", 2'b01, q[1:0])
    fetch(16'h0100, CMBM_SRC_ROM);
    `CHK("flash in code", 1'b0, fic)
    `CHK("data write ok", 1'b1, fwo)
    boot(1'b0);
    rw(1'b0, CMBM_CONF_ADDR, 8'h00, q);
    `CHK("conf reset", 32'h00000000, q)
    rw(1'b0, CMBM_STAT_ADDR, 8'h00, q);
    `CHK("boot state", 2'b10, q[1:0])
    fetch(CMBM_ROM_LAST, CMBM_SRC_ROM);
    i_core.fetch(16'h1000, 0, s, lat);
    `CHK("no flash fetch", 1'b1, s !== CMBM_SRC_FLASH)
    fetch(CMBM_STUB_FIRST, CMBM_SRC_STUB);
    rw(1'b0, CMBM_STAT_ADDR, 8'h00, q);
    `CHK("user state", 2'b11, q[1:0])
    `CHK("flash in code", 1'b1, fic)
    `CHK("switch pulses", 1, dones)
    `CHK("data write off", 1'b0, fwo)
    fetch(CMBM_APP_START, CMBM_SRC_FLASH);
    fetch(16'hFFF8, CMBM_SRC_FLASH);
    rw(1'b1, CMBM_CONF_ADDR, 8'h80, q);
    fetch(16'hFFFA, CMBM_SRC_STUB);
    rw(1'b1, CMBM_CONF_ADDR, 8'h80 & 8'h7F, q);
    fetch(16'hFFFA, CMBM_SRC_FLASH);
    // Bit 7 stays clear here so the timed fetches below come from flash.
    for (int i = 0; i < 6; i++) begin
      cfg = (i == 0) ? 8'h7F : 8'($random(seed)) & 8'h7F;
      ws = 8'($random(seed)) & 8'h07;
      rw(1'b1, CMBM_CONF_ADDR, cfg, q);
      rw(1'b0, CMBM_CONF_ADDR, 8'h00, q);
      `CHK("conf", {24'h000000, cfg & 8'hFB}, q)
      `CHK("prog enable", cfg[6], pm)
      `CHK("ext mode", cfg[5:3], em)
      rw(1'b1, CMBM_WAIT_ADDR, ws, q);
      rw(1'b0, CMBM_WAIT_ADDR, 8'h00, q);
      `CHK("wait states", {24'h000000, ws}, q)
      i_core.fetch(16'h0100, 0, s, lat);
      `CHK("fetch latency", int'(m_ws) + 2, lat)
    end
    rw(1'b1, 8'h10, 8'h5A, q);
    rw(1'b0, 8'h10, 8'h00, q);
    `CHK("unmapped", 32'h00000000, q)
    ext <= 1'b1;
    repeat (3) @(posedge clk_in);
    `CHK("grant open", 1'b1, grant)
    lock <= 1'b1;
    repeat (8) @(posedge clk_in);
    `CHK("grant locked", 1'b0, grant)
    lock <= 1'b0;
    repeat (8) @(posedge clk_in);
    `CHK("lock sticky", 1'b0, grant)
    print_verdict();
  end
endmodule
